/* pkg/gpk_pkg.sv */
// Constants, register map and carrier structs for the K/L/M/N port block
package gpk_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [31:0] IDX_PORT_M_PIN_DATA   = 32'hFFFFF0C0;
    localparam logic [31:0] IDX_PORT_L_PIN_DATA   = 32'hFFFFF0C1;
    localparam logic [31:0] IDX_PORT_K_PIN_DATA   = 32'hFFFFF0C2;
    localparam logic [31:0] IDX_PORT_M_DIRECTION  = 32'hFFFFF0C4;
    localparam logic [31:0] IDX_PORT_L_DIRECTION  = 32'hFFFFF0C5;
    localparam logic [31:0] IDX_PORT_K_DIRECTION  = 32'hFFFFF0C6;
    localparam logic [31:0] IDX_PORT_L_ALT_SELECT = 32'hFFFFF0C9;
    localparam logic [31:0] IDX_PORT_K_ALT_SELECT = 32'hFFFFF0CA;
    localparam logic [31:0] IDX_PORT_N_PIN_DATA   = 32'hFFFFF0D3;
    localparam logic [31:0] IDX_PORT_N_DIRECTION  = 32'hFFFFF0D7;
    localparam logic [31:0] IDX_PORT_N_ALT_SELECT = 32'hFFFFF0DB;
    localparam logic [31:0] IDX_PORT_N_DRAIN_MODE = 32'hFFFFF0DF;

    // Reset values
    localparam logic [7:0] RST_LATCH     = 8'hFF;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_ALT       = 8'h00;
    localparam logic [2:0] RST_N_ALT     = 3'h0;
    localparam logic [1:0] RST_N_DRAIN   = 2'h0;

    // Port N field positions
    localparam int N_TX_BIT    = 0;
    localparam int N_RX_BIT    = 1;
    localparam int N_CLK_BIT   = 2;
    localparam int N_ALT_W     = 3;
    localparam int N_DRAIN0    = 0;
    localparam int N_DRAIN2    = 2;

    // Idle level fed to the serial receive and clock inputs when their pin is not selected
    localparam logic IDLE_HIGH = 1'h1;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [7:0] k;
        logic [7:0] l;
        logic [7:0] m;
        logic [7:0] n;
    } gpk_pins_in_s;

    typedef struct packed {
        logic [7:0] k_out;
        logic [7:0] k_oe_n;
        logic [7:0] l_out;
        logic [7:0] l_oe_n;
        logic [7:0] m_out;
        logic [7:0] m_oe_n;
        logic [7:0] n_out;
        logic [7:0] n_oe_n;
    } gpk_pins_out_s;

    typedef struct packed {
        logic serial_transmit_pin;
        logic serial_clock_out;
    } gpk_serial_in_s;

    typedef struct packed {
        logic [7:0] key_wakeup_input;
        logic [3:0] eight_bit_timer_input;
        logic [1:0] wide_timer0_capture_in;
        logic [1:0] wide_timer1_capture_in;
        logic       serial_receive_pin;
        logic       serial_clock_in;
        logic       clear_to_send_input;
    } gpk_periph_out_s;

endpackage : gpk_pkg

/* verification/gpk_pin_model.sv */
// Board-side model of the port pins
`timescale 1ns/1ps
`default_nettype none
module gpk_pin_model (
    input  wire gpk_pkg::gpk_pins_out_s pins_out,
    input  wire gpk_pkg::gpk_pins_in_s  ext,
    output var  gpk_pkg::gpk_pins_in_s  pins_in
);
    // A released pin shows the board level, a driven one the block's level
    function automatic logic [7:0] res(input logic [7:0] o, e_n, b);
        return (o & ~e_n) | (b & e_n);
    endfunction : res
    assign pins_in.k = res(pins_out.k_out, pins_out.k_oe_n, ext.k);
    assign pins_in.l = res(pins_out.l_out, pins_out.l_oe_n, ext.l);
    assign pins_in.m = res(pins_out.m_out, pins_out.m_oe_n, ext.m);
    assign pins_in.n = res(pins_out.n_out, pins_out.n_oe_n, ext.n);
endmodule : gpk_pin_model
`default_nettype wire

/* verification/gpk_ports_sva.sv */
// Handshake, reset and routing checks
`timescale 1ns/1ps
`default_nettype none
module gpk_ports_sva (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [31:0]              s_axi_rdata,
    input wire logic                     s_axi_rvalid,
    input wire gpk_pkg::gpk_pins_in_s    pins_in,
    input wire gpk_pkg::gpk_pins_out_s   pins_out,
    input wire gpk_pkg::gpk_periph_out_s periph_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_ans;
        s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer");
    property p_rd_ans;
        s_rd_take |=> !s_axi_rvalid ##1 s_axi_rvalid && !(|s_axi_rdata[31:8]);
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer");
    property p_wr_hold;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write hold");
    property p_rd_hold;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read hold");
    property p_reset;
        $rose(aresetn) |-> pins_out == {8{8'hFF}} &&
            periph_out.key_wakeup_input == 8'hFF &&
            periph_out.eight_bit_timer_input == 4'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");
    property p_key;
        (~periph_out.key_wakeup_input & $past(pins_in.k)) == 8'h00;
    endproperty
    a_key: assert property (p_key) else $error("key route");
    property p_eight;
        (periph_out.eight_bit_timer_input & ~$past(pins_in.l[3:0])) == 4'h0;
    endproperty
    a_eight: assert property (p_eight) else $error("timer route");
    property p_wide;
        ({periph_out.wide_timer1_capture_in, periph_out.wide_timer0_capture_in}
            & ~$past(pins_in.l[7:4])) == 4'h0;
    endproperty
    a_wide: assert property (p_wide) else $error("capture route");
    property p_rx;
        !periph_out.serial_receive_pin |-> !$past(pins_in.n[1]);
    endproperty
    a_rx: assert property (p_rx) else $error("receive route");
    property p_clk;
        periph_out.clear_to_send_input == periph_out.serial_clock_in &&
            (periph_out.serial_clock_in || !$past(pins_in.n[2]));
    endproperty
    a_clk: assert property (p_clk) else $error("clock route");
endmodule : gpk_ports_sva
bind gpk_ports gpk_ports_sva gpk_ports_sva_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .pins_in, .pins_out, .periph_out);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    mismatches++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
    logic aclk, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    gpk_pkg::gpk_pins_in_s pins_in, ext = '0;
    gpk_pkg::gpk_pins_out_s pins_out;
    gpk_pkg::gpk_serial_in_s serial_in = '0;
    gpk_pkg::gpk_periph_out_s periph_out;
    int mismatches = 0, checks_done = 0, cyc = 0, seed = 35, p;
    logic [7:0] d, w, a, b;
    logic [31:0] dat_i [4] = '{gpk_pkg::IDX_PORT_K_PIN_DATA,
        gpk_pkg::IDX_PORT_L_PIN_DATA, gpk_pkg::IDX_PORT_M_PIN_DATA,
        gpk_pkg::IDX_PORT_N_PIN_DATA};
    logic [31:0] dir_i [4] = '{gpk_pkg::IDX_PORT_K_DIRECTION,
        gpk_pkg::IDX_PORT_L_DIRECTION, gpk_pkg::IDX_PORT_M_DIRECTION,
        gpk_pkg::IDX_PORT_N_DIRECTION};
    gpk_ports gpk_ports_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pins_in, .pins_out, .serial_in, .periph_out);
    gpk_pin_model gpk_pin_model_i (.pins_out, .ext, .pins_in);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    function automatic logic [11:0] ad(input logic [31:0] i);
        return {i[9:0], 2'b00};
    endfunction : ad
    task automatic wr(input logic [31:0] i, input logic [7:0] x);
        s_axi_awaddr <= ad(i);
        s_axi_wdata <= {24'h0, x};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [31:0] i);
        s_axi_araddr <= ad(i);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic test_done();
        if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(pins_out, {8{8'hFF}})
        for (p = 0; p < 4; p++) begin
            ext <= $random(seed);
            d = $random(seed);
            w = $random(seed);
            wr(dat_i[p], w);
            `CHK(r, gpk_pkg::RESP_OKAY)
            wr(dir_i[p], d);
            rd(dir_i[p]);
            `CHK(v, 32'h0)
            rd(dat_i[p]);
            `CHK(v[7:0], (w & d) | (ext[31-8*p -: 8] & ~d))
            `CHK(pins_out[55-16*p -: 8], ~d)
            `CHK(pins_out[63-16*p -: 8] & d, w & d)
        end
        for (p = 0; p < 4; p++) wr(dir_i[p], 8'h00);
        a = $random(seed);
        b = $random(seed);
        wr(gpk_pkg::IDX_PORT_K_ALT_SELECT, a);
        wr(gpk_pkg::IDX_PORT_L_ALT_SELECT, b);
        wr(gpk_pkg::IDX_PORT_N_ALT_SELECT, 8'hFE);
        repeat (2) @(posedge aclk);
        `CHK(periph_out.key_wakeup_input, (ext.k & a) | ~a)
        `CHK(periph_out.eight_bit_timer_input, ext.l[3:0] & b[3:0])
        `CHK({periph_out.wide_timer1_capture_in,
            periph_out.wide_timer0_capture_in}, ext.l[7:4] & b[7:4])
        `CHK(periph_out.serial_receive_pin, ext.n[1])
        `CHK(periph_out.clear_to_send_input, ext.n[2])
        rd(gpk_pkg::IDX_PORT_N_ALT_SELECT);
        `CHK(v, 32'h0)
        wr(dat_i[3], 8'h08);
        wr(dir_i[3], 8'h09);
        wr(gpk_pkg::IDX_PORT_N_ALT_SELECT, 8'hFF);
        for (p = 1; p >= 0; p--) begin
            serial_in <= {2{p[0]}};
            repeat (2) @(posedge aclk);
            `CHK(pins_out.n_out[0], p[0])
        end
        `CHK(pins_out.n_out[3] & ~pins_out.n_oe_n[3], 1'b1)
        wr(gpk_pkg::IDX_PORT_N_ALT_SELECT, 8'h00);
        wr(gpk_pkg::IDX_PORT_N_DRAIN_MODE, 8'h05);
        wr(dat_i[3], 8'h04);
        wr(dir_i[3], 8'h05);
        `CHK({pins_out.n_oe_n[2], pins_out.n_oe_n[0], pins_out.n_out[0]},
            3'b100)
        wr(32'h3FF, 8'h00);
        `CHK(r, gpk_pkg::RESP_DECERR)
        rd(32'h3FF);
        `CHK(r, gpk_pkg::RESP_DECERR)
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(pins_out, {8{8'hFF}})
        `CHK(periph_out.key_wakeup_input, 8'hFF)
        rd(dat_i[3]);
        `CHK(v[7:0], ext.n)
        test_done();
    end
endmodule : tb
`default_nettype wire

/* verilog/gpk_ports.sv */
// Ports K, L, M and N with direction, alternate function and AXI4-Lite access
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Port K direction bits: 0 input, 1 output; write-only, reset to 0.
// - Port K function bit 1 routes pin to same-index key wake-up input.
// - After reset all pins are inputs and every output latch holds 1.
// - Each port L pin is either plain I/O or a timer input.
// - Port L direction register sets each pin: 0 input, 1 output.
// - Port L pins 0-3 feed 8-bit timer inputs 4, 6, 8, A.
// - Port L pins 4-7 feed capture inputs of 16-bit timers 0 and 1.
// - Port L function bit 1 connects timer input; 0 plain; write-only.
// - Reset clears port L direction and function bits.
// - Port M is plain I/O; write-only direction bits reset to 0.
// - Port N direction bits: 0 input, 1 output, per pin, write-only.
// - Port N pin 0 with function set carries serial transmit data.
// - Port N pin 1 with function set carries serial receive data.
// - Port N pin 2 with function set is serial clock or clear-to-send.
// - Only port N function bits 0-2 exist; pins 3-7 stay plain.
// - Reset clears port N direction and function bits.
// - Port N drain bits 2 and 0: 0 push-pull, 1 open-drain; reset 0.
module gpk_ports #(
    parameter int ADDR_W = 12
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output var  logic                     s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output var  logic                     s_axi_wready,
    output var  logic [1:0]               s_axi_bresp,
    output var  logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output var  logic                     s_axi_arready,
    output var  logic [31:0]              s_axi_rdata,
    output var  logic [1:0]               s_axi_rresp,
    output var  logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire gpk_pkg::gpk_pins_in_s    pins_in,
    output var  gpk_pkg::gpk_pins_out_s   pins_out,
    input  wire gpk_pkg::gpk_serial_in_s  serial_in,
    output var  gpk_pkg::gpk_periph_out_s periph_out
);

    localparam int IW = ADDR_W - 2;

    typedef struct packed {
        logic [7:0]                latch_k;
        logic [7:0]                latch_l;
        logic [7:0]                latch_m;
        logic [7:0]                latch_n;
        logic [7:0]                dir_k;
        logic [7:0]                dir_l;
        logic [7:0]                dir_m;
        logic [7:0]                dir_n;
        logic [7:0]                alt_k;
        logic [7:0]                alt_l;
        logic [2:0]                alt_n;
        logic [1:0]                drain_n;
        logic                      awready;
        logic                      wready;
        logic [IW-1:0]             wr_index;
        logic [7:0]                wr_byte;
        logic                      wr_lane;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic [IW-1:0]             rd_index;
        logic                      rd_pend;
        logic                      rvalid;
        logic [7:0]                rdata;
        logic [1:0]                rresp;
        gpk_pkg::gpk_pins_out_s    pins;
        gpk_pkg::gpk_periph_out_s  periph;
    } gpk_state_s;

    gpk_state_s state_reg;
    gpk_state_s state_next;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic idx_hit(input logic [IW-1:0] idx,
                                     input logic [31:0]   reg_idx);
        idx_hit = (idx == reg_idx[IW-1:0]);
    endfunction : idx_hit

    // Pin readback: latch where driven, pin level where input
    function automatic logic [7:0] readback(input logic [7:0] dir,
                                            input logic [7:0] latch,
                                            input logic [7:0] pin);
        readback = (dir & latch) | (~dir & pin);
    endfunction : readback

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [7:0] n_val;
        logic [7:0] n_drive;
        logic       wr_ok;
        n_val     = 8'h00;
        n_drive   = 8'h00;
        wr_ok     = 1'b0;
        state_next = state_reg;

        // Write address and data are taken independently
        if (state_reg.awready && s_axi_awvalid) begin
            state_next.awready  = 1'b0;
            state_next.wr_index = s_axi_awaddr[ADDR_W-1:2];
        end
        if (state_reg.wready && s_axi_wvalid) begin
            state_next.wready  = 1'b0;
            state_next.wr_byte = s_axi_wdata[7:0];
            state_next.wr_lane = s_axi_wstrb[0];
        end

        // Both halves held: perform the write and answer
        if (!state_reg.awready && !state_reg.wready && !state_reg.bvalid) begin
            wr_ok = 1'b1;
            if (idx_hit(state_reg.wr_index, gpk_pkg::IDX_PORT_M_PIN_DATA)
            ) begin
                if (state_reg.wr_lane) begin
                    state_next.latch_m = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_L_PIN_DATA)) begin
                if (state_reg.wr_lane) begin
                    state_next.latch_l = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_K_PIN_DATA)) begin
                if (state_reg.wr_lane) begin
                    state_next.latch_k = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_N_PIN_DATA)) begin
                if (state_reg.wr_lane) begin
                    state_next.latch_n = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_M_DIRECTION)) begin
                if (state_reg.wr_lane) begin
                    state_next.dir_m = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_L_DIRECTION)) begin
                if (state_reg.wr_lane) begin
                    state_next.dir_l = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_K_DIRECTION)) begin
                if (state_reg.wr_lane) begin
                    state_next.dir_k = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_N_DIRECTION)) begin
                if (state_reg.wr_lane) begin
                    state_next.dir_n = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_L_ALT_SELECT)) begin
                if (state_reg.wr_lane) begin
                    state_next.alt_l = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_K_ALT_SELECT)) begin
                if (state_reg.wr_lane) begin
                    state_next.alt_k = state_reg.wr_byte;
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_N_ALT_SELECT)) begin
                if (state_reg.wr_lane) begin
                    state_next.alt_n =
                        state_reg.wr_byte[gpk_pkg::N_ALT_W-1:0];
                end
            end else if (idx_hit(state_reg.wr_index,
                                 gpk_pkg::IDX_PORT_N_DRAIN_MODE)) begin
                if (state_reg.wr_lane) begin
                    state_next.drain_n = {
                        state_reg.wr_byte[gpk_pkg::N_DRAIN2],
                        state_reg.wr_byte[gpk_pkg::N_DRAIN0]};
                end
            end else begin
                wr_ok = 1'b0;
            end
            state_next.bvalid = 1'b1;
            state_next.bresp  = wr_ok ? gpk_pkg::RESP_OKAY
                                      : gpk_pkg::RESP_DECERR;
        end

        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid  = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready  = 1'b1;
        end

        // Read channel; configuration registers read as zero
        if (state_reg.arready && s_axi_arvalid) begin
            state_next.arready  = 1'b0;
            state_next.rd_index = s_axi_araddr[ADDR_W-1:2];
            state_next.rd_pend  = 1'b1;
        end
        if (state_reg.rd_pend) begin
            state_next.rd_pend = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rdata   = 8'h00;
            state_next.rresp   = gpk_pkg::RESP_OKAY;
            if (idx_hit(state_reg.rd_index, gpk_pkg::IDX_PORT_M_PIN_DATA)
            ) begin
                state_next.rdata = readback(state_reg.dir_m,
                                            state_reg.latch_m, pins_in.m);
            end else if (idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_L_PIN_DATA)) begin
                state_next.rdata = readback(state_reg.dir_l,
                                            state_reg.latch_l, pins_in.l);
            end else if (idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_K_PIN_DATA)) begin
                state_next.rdata = readback(state_reg.dir_k,
                                            state_reg.latch_k, pins_in.k);
            end else if (idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_N_PIN_DATA)) begin
                state_next.rdata = readback(state_reg.dir_n,
                                            state_reg.latch_n, pins_in.n);
            end else if (idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_M_DIRECTION)
                      || idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_L_DIRECTION)
                      || idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_K_DIRECTION)
                      || idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_N_DIRECTION)
                      || idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_L_ALT_SELECT)
                      || idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_K_ALT_SELECT)
                      || idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_N_ALT_SELECT)
                      || idx_hit(state_reg.rd_index,
                                 gpk_pkg::IDX_PORT_N_DRAIN_MODE)) begin
                state_next.rdata = 8'h00;
            end else begin
                state_next.rresp = gpk_pkg::RESP_DECERR;
            end
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid  = 1'b0;
            state_next.arready = 1'b1;
        end

        // Reset overrides everything
        if (!aresetn) begin
            state_next.latch_k  = gpk_pkg::RST_LATCH;
            state_next.latch_l  = gpk_pkg::RST_LATCH;
            state_next.latch_m  = gpk_pkg::RST_LATCH;
            state_next.latch_n  = gpk_pkg::RST_LATCH;
            state_next.dir_k    = gpk_pkg::RST_DIRECTION;
            state_next.dir_l    = gpk_pkg::RST_DIRECTION;
            state_next.dir_m    = gpk_pkg::RST_DIRECTION;
            state_next.dir_n    = gpk_pkg::RST_DIRECTION;
            state_next.alt_k    = gpk_pkg::RST_ALT;
            state_next.alt_l    = gpk_pkg::RST_ALT;
            state_next.alt_n    = gpk_pkg::RST_N_ALT;
            state_next.drain_n  = gpk_pkg::RST_N_DRAIN;
            state_next.awready  = 1'b1;
            state_next.wready   = 1'b1;
            state_next.wr_index = '0;
            state_next.wr_byte  = 8'h00;
            state_next.wr_lane  = 1'b0;
            state_next.bvalid   = 1'b0;
            state_next.bresp    = gpk_pkg::RESP_OKAY;
            state_next.arready  = 1'b1;
            state_next.rd_index = '0;
            state_next.rd_pend  = 1'b0;
            state_next.rvalid   = 1'b0;
            state_next.rdata    = 8'h00;
            state_next.rresp    = gpk_pkg::RESP_OKAY;
        end

        // Pin drive
        state_next.pins.k_out  = state_next.latch_k;
        state_next.pins.k_oe_n = ~state_next.dir_k;
        state_next.pins.l_out  = state_next.latch_l;
        state_next.pins.l_oe_n = ~state_next.dir_l;
        state_next.pins.m_out  = state_next.latch_m;
        state_next.pins.m_oe_n = ~state_next.dir_m;

        n_val   = state_next.latch_n;
        n_drive = state_next.dir_n;
        if (state_next.alt_n[gpk_pkg::N_TX_BIT]) begin
            n_val[gpk_pkg::N_TX_BIT] = serial_in.serial_transmit_pin;
        end
        if (state_next.alt_n[gpk_pkg::N_CLK_BIT]) begin
            n_val[gpk_pkg::N_CLK_BIT] = serial_in.serial_clock_out;
        end
        // Open-drain pins only ever pull low
        if (state_next.drain_n[0]) begin
            n_drive[gpk_pkg::N_DRAIN0] = n_drive[gpk_pkg::N_DRAIN0]
                                       & ~n_val[gpk_pkg::N_DRAIN0];
            n_val[gpk_pkg::N_DRAIN0]   = 1'b0;
        end
        if (state_next.drain_n[1]) begin
            n_drive[gpk_pkg::N_DRAIN2] = n_drive[gpk_pkg::N_DRAIN2]
                                       & ~n_val[gpk_pkg::N_DRAIN2];
            n_val[gpk_pkg::N_DRAIN2]   = 1'b0;
        end
        state_next.pins.n_out  = n_val;
        state_next.pins.n_oe_n = ~n_drive;

        // Peripheral inputs
        state_next.periph.key_wakeup_input =
            (pins_in.k & state_next.alt_k) | ~state_next.alt_k;
        state_next.periph.eight_bit_timer_input =
            pins_in.l[3:0] & state_next.alt_l[3:0];
        state_next.periph.wide_timer0_capture_in =
            pins_in.l[5:4] & state_next.alt_l[5:4];
        state_next.periph.wide_timer1_capture_in =
            pins_in.l[7:6] & state_next.alt_l[7:6];
        state_next.periph.serial_receive_pin =
            state_next.alt_n[gpk_pkg::N_RX_BIT] ? pins_in.n[gpk_pkg::N_RX_BIT]
                                                : gpk_pkg::IDLE_HIGH;
        state_next.periph.serial_clock_in =
            (state_next.alt_n[gpk_pkg::N_CLK_BIT]
             && !state_next.dir_n[gpk_pkg::N_CLK_BIT])
                ? pins_in.n[gpk_pkg::N_CLK_BIT]
                : gpk_pkg::IDLE_HIGH;
        state_next.periph.clear_to_send_input =
            state_next.periph.serial_clock_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk) begin
        state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready  = state_reg.wready;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rresp   = state_reg.rresp;
    assign s_axi_rdata   = {24'h000000, state_reg.rdata};
    assign pins_out      = state_reg.pins;
    assign periph_out    = state_reg.periph;

endmodule : gpk_ports

`default_nettype wire
